// File: core/rtcoc_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the RTC oscillator control and missing-clock monitor.
 * Assumes an 8-bit register port with a 4-bit internal address.
 */
// Behaviour
// - RTC timebase stays independent of system clock
// - Crystal 32.768 kHz or self-oscillate 20/40 kHz
// - Mode bit 1 crystal, 0 self-oscillate
// - Self-oscillate: bias bit 0 20k, 1 40k
// - Self-oscillate runs at once, no polling
// - Osc control bit 7 enables gain control
// - Osc control bit 5 doubles bias current
// - Control bit 6 enables one-shot clock monitor
// - Flag bit 5 when clock stuck >50 us
// - Timeout wakes internal oscillator from suspend
// - Timeout raises interrupt only when enabled
// - Timeout requests reset only when enabled
// - RTC clock selectable as system clock, pin-routable
// - RTC edges feed timer 2/3 capture
`ifndef RTCOC_REGS_SVH
`define RTCOC_REGS_SVH

`define RTCOC_ADDR_W            4
`define RTCOC_DATA_W            8

`define RTCOC_RTC_CTRL_ADDR     4'h6
`define RTCOC_OSC_CTRL_ADDR     4'h7
`define RTCOC_CLK_ROUTE_ADDR    4'hE
`define RTCOC_EVT_EN_ADDR       4'hF

`define RTCOC_CTRL_POWER_BIT    7
`define RTCOC_CTRL_MCLK_BIT     6
`define RTCOC_CTRL_FAIL_BIT     5

`define RTCOC_OSC_GAIN_BIT      7
`define RTCOC_OSC_MODE_BIT      6
`define RTCOC_OSC_BIAS_BIT      5
`define RTCOC_OSC_VALID_BIT     4

`define RTCOC_ROUTE_SYS_CLK_BIT 0
`define RTCOC_ROUTE_PIN_BIT     1
`define RTCOC_EVT_IRQ_BIT       0
`define RTCOC_EVT_RST_BIT       1

`define RTCOC_RTC_CTRL_RESET    8'h00
`define RTCOC_OSC_CTRL_RESET    8'h00
`define RTCOC_CLK_ROUTE_RESET   8'h00
`define RTCOC_EVT_EN_RESET      8'h00

`define RTCOC_CLK_MHZ           10
`define RTCOC_MCD_TIMEOUT_NS    50000
`define RTCOC_MCD_CYCLES        ((`RTCOC_MCD_TIMEOUT_NS * `RTCOC_CLK_MHZ) / 1000)
`define RTCOC_MCD_CNT_W         10

`endif

// File: core/rtcoc_pkg.sv
/*
 * Types for the RTC oscillator control block.
 * Assumes rtcoc_regs.svh for widths.
 */
`default_nettype none
`include "rtcoc_regs.svh"

package rtcoc_pkg;

    typedef enum logic {
        OSC_SELF,
        OSC_CRYSTAL
    } rtcoc_osc_mode_e;

    typedef enum logic [1:0] {
        MCD_IDLE,
        MCD_WATCH,
        MCD_TRIPPED
    } rtcoc_mcd_state_e;

    typedef struct packed {
        logic                           power_en;
        logic                           mclk_en;
        logic                           osc_fail;
        logic                           gain_en;
        rtcoc_osc_mode_e                mode_sel;
        logic                           bias_dbl;
        logic                           irq_en;
        logic                           rst_en;
        logic                           sys_clk_sel;
        logic                           pin_route;
        logic [`RTCOC_DATA_W-1:0]       rd_data;
        rtcoc_mcd_state_e               mcd_state;
        logic [`RTCOC_MCD_CNT_W-1:0]    mcd_count;
        logic                           rtc_prev;
        logic                           rtc_edge;
        logic                           clk_valid;
        logic                           wake;
        logic                           irq;
        logic                           rst_req;
    } rtcoc_state_s;

endpackage : rtcoc_pkg

`default_nettype wire

// File: core/rtcoc_sync.sv
/*
 * Two-flop synchroniser for levels entering the system clock domain.
 * Assumes inputs may change at any time relative to the clock.
 */
`timescale 1ns/1ps
`default_nettype none

module rtcoc_sync (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] async_i,
    output logic      [1:0] sync_o
);

    logic [1:0] stage1_reg;
    logic [1:0] stage2_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stage1_reg <= 2'h0;
            stage2_reg <= 2'h0;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_o = stage2_reg;

endmodule : rtcoc_sync

`default_nettype wire

// File: core/rtcoc_ctrl.sv
/*
 * RTC oscillator control and missing-clock monitor.
 * Holds the oscillator control and RTC control registers, drives the
 * analog oscillator controls, routes the RTC clock and watches it for
 * a stuck level, raising wake, interrupt and reset requests.
 * Assumes an 8-bit register port with one-cycle strobes and read data
 * the cycle after the read strobe; RTC clock is a free-running level
 * from the oscillator, sampled here by a synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rtcoc_regs.svh"

module rtcoc_ctrl (
    input  wire logic                     CORE_CLK_I,
    input  wire logic                     RST_N_I,
    input  wire logic [`RTCOC_ADDR_W-1:0] REG_ADDR_I,
    input  wire logic [`RTCOC_DATA_W-1:0] REG_WDATA_I,
    input  wire logic                     REG_WR_I,
    input  wire logic                     REG_RD_I,
    output logic      [`RTCOC_DATA_W-1:0] REG_RDATA_O,
    input  wire logic                     RTC_CLK_I,
    input  wire logic                     XTAL_STABLE_I,
    output logic                          OSC_MODE_SELECT_O,
    output logic                          GAIN_CONTROL_ENABLE_O,
    output logic                          BIAS_DOUBLE_ENABLE_O,
    output logic                          RTC_OSC_POWER_ENABLE_O,
    output logic                          SYS_CLOCK_SEL_RTC_O,
    output logic                          PIN_ROUTE_RTC_O,
    output logic                          CAPTURE_EDGE_O,
    output logic                          WAKE_REQ_O,
    output logic                          IRQ_O,
    output logic                          RESET_REQ_O
);

    localparam logic [`RTCOC_MCD_CNT_W-1:0] MCD_LAST =
        `RTCOC_MCD_CNT_W'(`RTCOC_MCD_CYCLES - 1);

    localparam logic [`RTCOC_DATA_W-1:0] CTRL_RST  = `RTCOC_RTC_CTRL_RESET;
    localparam logic [`RTCOC_DATA_W-1:0] OSC_RST   = `RTCOC_OSC_CTRL_RESET;
    localparam logic [`RTCOC_DATA_W-1:0] ROUTE_RST = `RTCOC_CLK_ROUTE_RESET;
    localparam logic [`RTCOC_DATA_W-1:0] EVT_RST   = `RTCOC_EVT_EN_RESET;

    rtcoc_pkg::rtcoc_state_s state_reg;
    rtcoc_pkg::rtcoc_state_s state_next;

    logic [1:0] sync_out;
    logic       rtc_sync;
    logic       xtal_sync;
    logic       wr_ctrl;
    logic       wr_osc;
    logic       wr_route;
    logic       wr_evt;
    logic       fail_clear;
    logic       mcd_timeout;

    // RTC clock is sampled, never used as a clock here
    rtcoc_sync u_sync (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .async_i ({XTAL_STABLE_I, RTC_CLK_I}),
        .sync_o  (sync_out)
    );

    assign rtc_sync  = sync_out[0];
    assign xtal_sync = sync_out[1];

    // Write decode
    assign wr_ctrl  = REG_WR_I && (REG_ADDR_I == `RTCOC_RTC_CTRL_ADDR);
    assign wr_osc   = REG_WR_I && (REG_ADDR_I == `RTCOC_OSC_CTRL_ADDR);
    assign wr_route = REG_WR_I && (REG_ADDR_I == `RTCOC_CLK_ROUTE_ADDR);
    assign wr_evt   = REG_WR_I && (REG_ADDR_I == `RTCOC_EVT_EN_ADDR);

    // Writing 0 to the fail flag clears it; writing 1 leaves it
    assign fail_clear = wr_ctrl && !REG_WDATA_I[`RTCOC_CTRL_FAIL_BIT];

    // Stuck level: no edge for the whole window while watching
    assign mcd_timeout = (state_reg.mcd_state == rtcoc_pkg::MCD_WATCH)
                         && (rtc_sync == state_reg.rtc_prev)
                         && state_reg.mclk_en
                         && (state_reg.mcd_count == MCD_LAST);

    always_comb begin
        state_next = state_reg;

        // One-cycle pulses default low
        state_next.rtc_edge = 1'b0;
        state_next.wake     = 1'b0;
        state_next.rst_req  = 1'b0;
        state_next.rd_data  = '0;

        // RTC control register
        if (wr_ctrl) begin
            state_next.power_en = REG_WDATA_I[`RTCOC_CTRL_POWER_BIT];
            state_next.mclk_en  = REG_WDATA_I[`RTCOC_CTRL_MCLK_BIT];
        end

        // Oscillator control register
        if (wr_osc) begin
            state_next.gain_en  = REG_WDATA_I[`RTCOC_OSC_GAIN_BIT];
            state_next.mode_sel = REG_WDATA_I[`RTCOC_OSC_MODE_BIT]
                                  ? rtcoc_pkg::OSC_CRYSTAL
                                  : rtcoc_pkg::OSC_SELF;
            state_next.bias_dbl = REG_WDATA_I[`RTCOC_OSC_BIAS_BIT];
        end

        // Clock routing register
        if (wr_route) begin
            state_next.sys_clk_sel = REG_WDATA_I[`RTCOC_ROUTE_SYS_CLK_BIT];
            state_next.pin_route  = REG_WDATA_I[`RTCOC_ROUTE_PIN_BIT];
        end

        // Event enable register
        if (wr_evt) begin
            state_next.irq_en = REG_WDATA_I[`RTCOC_EVT_IRQ_BIT];
            state_next.rst_en = REG_WDATA_I[`RTCOC_EVT_RST_BIT];
        end

        // Clock valid: crystal waits for stability, self-oscillate at once
        if (!state_reg.power_en) begin
            state_next.clk_valid = 1'b0;
        end else if (state_reg.mode_sel == rtcoc_pkg::OSC_SELF) begin
            state_next.clk_valid = 1'b1;
        end else begin
            state_next.clk_valid = xtal_sync;
        end

        // Edge tracking of the synchronised RTC clock
        state_next.rtc_prev = rtc_sync;
        if (rtc_sync && !state_reg.rtc_prev) begin
            state_next.rtc_edge = 1'b1;
        end

        // Missing-clock monitor, one-shot until flag clear or disable
        unique case (state_reg.mcd_state)
            rtcoc_pkg::MCD_IDLE: begin
                state_next.mcd_count = '0;
                if (state_reg.mclk_en && !state_reg.osc_fail) begin
                    state_next.mcd_state = rtcoc_pkg::MCD_WATCH;
                end
            end
            rtcoc_pkg::MCD_WATCH: begin
                if (!state_reg.mclk_en) begin
                    state_next.mcd_state = rtcoc_pkg::MCD_IDLE;
                    state_next.mcd_count = '0;
                end else if (rtc_sync != state_reg.rtc_prev) begin
                    state_next.mcd_count = '0;
                end else if (mcd_timeout) begin
                    state_next.mcd_state = rtcoc_pkg::MCD_TRIPPED;
                    state_next.mcd_count = '0;
                    state_next.wake      = 1'b1;
                    state_next.rst_req   = state_reg.rst_en;
                end else begin
                    state_next.mcd_count = state_reg.mcd_count
                                           + `RTCOC_MCD_CNT_W'(1);
                end
            end
            rtcoc_pkg::MCD_TRIPPED: begin
                state_next.mcd_count = '0;
                if (!state_reg.mclk_en || !state_reg.osc_fail) begin
                    state_next.mcd_state = rtcoc_pkg::MCD_IDLE;
                end
            end
            default: begin
                state_next.mcd_state = rtcoc_pkg::MCD_IDLE;
                state_next.mcd_count = '0;
            end
        endcase

        // Fail flag: hardware set wins over a software clear
        if (mcd_timeout) begin
            state_next.osc_fail = 1'b1;
        end else if (fail_clear) begin
            state_next.osc_fail = 1'b0;
        end

        // Interrupt follows the flag while enabled
        state_next.irq = state_next.osc_fail && state_next.irq_en;

        // Read port, data in the cycle after the strobe
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                `RTCOC_RTC_CTRL_ADDR: begin
                    state_next.rd_data[`RTCOC_CTRL_POWER_BIT] = state_reg.power_en;
                    state_next.rd_data[`RTCOC_CTRL_MCLK_BIT]  = state_reg.mclk_en;
                    state_next.rd_data[`RTCOC_CTRL_FAIL_BIT]  = state_reg.osc_fail;
                end
                `RTCOC_OSC_CTRL_ADDR: begin
                    state_next.rd_data[`RTCOC_OSC_GAIN_BIT]  = state_reg.gain_en;
                    state_next.rd_data[`RTCOC_OSC_MODE_BIT]  =
                        (state_reg.mode_sel == rtcoc_pkg::OSC_CRYSTAL);
                    state_next.rd_data[`RTCOC_OSC_BIAS_BIT]  = state_reg.bias_dbl;
                    state_next.rd_data[`RTCOC_OSC_VALID_BIT] = state_reg.clk_valid;
                end
                `RTCOC_CLK_ROUTE_ADDR: begin
                    state_next.rd_data[`RTCOC_ROUTE_SYS_CLK_BIT] = state_reg.sys_clk_sel;
                    state_next.rd_data[`RTCOC_ROUTE_PIN_BIT]     = state_reg.pin_route;
                end
                `RTCOC_EVT_EN_ADDR: begin
                    state_next.rd_data[`RTCOC_EVT_IRQ_BIT] = state_reg.irq_en;
                    state_next.rd_data[`RTCOC_EVT_RST_BIT] = state_reg.rst_en;
                end
                default: begin
                    state_next.rd_data = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            state_reg            <= '0;
            state_reg.power_en   <= CTRL_RST[`RTCOC_CTRL_POWER_BIT];
            state_reg.mclk_en    <= CTRL_RST[`RTCOC_CTRL_MCLK_BIT];
            state_reg.osc_fail   <= CTRL_RST[`RTCOC_CTRL_FAIL_BIT];
            state_reg.gain_en    <= OSC_RST[`RTCOC_OSC_GAIN_BIT];
            state_reg.mode_sel   <= rtcoc_pkg::OSC_SELF;
            state_reg.bias_dbl   <= OSC_RST[`RTCOC_OSC_BIAS_BIT];
            state_reg.sys_clk_sel <= ROUTE_RST[`RTCOC_ROUTE_SYS_CLK_BIT];
            state_reg.pin_route  <= ROUTE_RST[`RTCOC_ROUTE_PIN_BIT];
            state_reg.irq_en     <= EVT_RST[`RTCOC_EVT_IRQ_BIT];
            state_reg.rst_en     <= EVT_RST[`RTCOC_EVT_RST_BIT];
            state_reg.mcd_state  <= rtcoc_pkg::MCD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state flops
    assign REG_RDATA_O            = state_reg.rd_data;
    assign OSC_MODE_SELECT_O      = (state_reg.mode_sel == rtcoc_pkg::OSC_CRYSTAL);
    assign GAIN_CONTROL_ENABLE_O  = state_reg.gain_en;
    assign BIAS_DOUBLE_ENABLE_O   = state_reg.bias_dbl;
    assign RTC_OSC_POWER_ENABLE_O = state_reg.power_en;
    assign SYS_CLOCK_SEL_RTC_O    = state_reg.sys_clk_sel;
    assign PIN_ROUTE_RTC_O        = state_reg.pin_route;
    assign CAPTURE_EDGE_O         = state_reg.rtc_edge;
    assign WAKE_REQ_O             = state_reg.wake;
    assign IRQ_O                  = state_reg.irq;
    assign RESET_REQ_O            = state_reg.rst_req;

endmodule : rtcoc_ctrl

`default_nettype wire

// File: sim/rtcoc_ctrl_monitor.sv
/*
 * Port checker for the RTC oscillator control block.
 * Assumes it is bound onto rtcoc_ctrl with a single core clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rtcoc_regs.svh"

module rtcoc_ctrl_monitor (
    input  wire logic       CORE_CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic [3:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_WR_I,
    input  wire logic       RTC_CLK_I,
    input  wire logic       OSC_MODE_SELECT_O,
    input  wire logic       GAIN_CONTROL_ENABLE_O,
    input  wire logic       BIAS_DOUBLE_ENABLE_O,
    input  wire logic       RTC_OSC_POWER_ENABLE_O,
    input  wire logic       SYS_CLOCK_SEL_RTC_O,
    input  wire logic       PIN_ROUTE_RTC_O,
    input  wire logic       CAPTURE_EDGE_O,
    input  wire logic       WAKE_REQ_O,
    input  wire logic       IRQ_O,
    input  wire logic       RESET_REQ_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    logic       rtc_last;
    logic [9:0] stuck_cnt;

    // Cycles since the raw RTC level last moved
    always_ff @(posedge CORE_CLK_I) begin
        rtc_last <= RTC_CLK_I;
        if (!RST_N_I || (RTC_CLK_I != rtc_last)) begin
            stuck_cnt <= 10'h000;
        end else if (stuck_cnt != 10'h3FF) begin
            stuck_cnt <= stuck_cnt + 10'h001;
        end
    end

    chk_osc_outputs: assert property (REG_WR_I && REG_ADDR_I == 4'h7 |=>
        {GAIN_CONTROL_ENABLE_O, OSC_MODE_SELECT_O, BIAS_DOUBLE_ENABLE_O} == $past(REG_WDATA_I[7:5]))
        else $error("osc control outputs do not follow write");
    chk_power_output: assert property (REG_WR_I && REG_ADDR_I == 4'h6 |=>
        RTC_OSC_POWER_ENABLE_O == $past(REG_WDATA_I[7])) else $error("power output does not follow write");
    chk_clock_route: assert property (REG_WR_I && REG_ADDR_I == 4'hE |=>
        {PIN_ROUTE_RTC_O, SYS_CLOCK_SEL_RTC_O} == $past(REG_WDATA_I[1:0])) else $error("route outputs wrong");
    chk_capture_lag: assert property ($rose(RTC_CLK_I) |-> ##3 CAPTURE_EDGE_O)
        else $error("capture pulse missing");
    chk_wake_single: assert property (WAKE_REQ_O |=> !WAKE_REQ_O [*8])
        else $error("wake repeated");
    chk_wake_stuck: assert property (WAKE_REQ_O |-> stuck_cnt >= 10'h1F4)
        else $error("wake before clock stuck long enough");
    chk_reset_with_wake: assert property (RESET_REQ_O |-> WAKE_REQ_O)
        else $error("reset request without timeout");
    chk_reset_pulse: assert property (RESET_REQ_O |=> !RESET_REQ_O)
        else $error("reset request longer than one cycle");
    chk_irq_cause: assert property ($rose(IRQ_O) |-> WAKE_REQ_O || $past(REG_WR_I) || $past(REG_WR_I, 2))
        else $error("interrupt rose without cause");
endmodule : rtcoc_ctrl_monitor

bind rtcoc_ctrl rtcoc_ctrl_monitor u_rtcoc_ctrl_monitor (.*);

`default_nettype wire

// File: sim/rtcoc_osc_model.sv
/*
 * Behavioural RTC oscillator.
 * Assumes the bench commands a stuck clock through hold_i.
 */
`timescale 1ns/1ps
`default_nettype none

module rtcoc_osc_model (
    input  wire logic power_i,
    input  wire logic mode_i,
    input  wire logic bias_i,
    input  wire logic hold_i,
    output logic      rtc_clk_o,
    output logic      xtal_stable_o
);
    int edges;

    // Own timebase, unrelated to the core clock
    initial begin
        rtc_clk_o = 1'b0;
        edges = 0;
        forever begin
            if (!power_i || !mode_i) edges = 0;
            if (power_i && !hold_i) begin
                // Crystal 32.768 kHz, self 40 or 20 kHz
                #(mode_i ? 15259 : (bias_i ? 12500 : 25000));
                rtc_clk_o = ~rtc_clk_o;
                edges++;
            end else begin
                #100;
            end
        end
    end

    // Self mode runs at once; crystal settles after 16 edges
    assign xtal_stable_o = power_i && mode_i && (edges >= 16);
endmodule : rtcoc_osc_model

`default_nettype wire

// File: sim/rtcoc_ctrl_bench.sv
/*
 * Self-checking bench for the RTC oscillator control block.
 * Assumes rtcoc_osc_model stands in for the analog oscillator.
 */
`timescale 1ns/1ps
`default_nettype none

module rtcoc_ctrl_bench;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       hold = 1'b0;
    logic [7:0] rdata;
    logic       rtc_clk, xtal_ok, mode, gain, bias, power, sys_clk, pin, cap, wake, irq, rstq;
    int         bad_count = 0;
    int         checks_done = 0;

    always #50 clk = ~clk;

    rtcoc_ctrl u_rtcoc_ctrl (.CORE_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .RTC_CLK_I(rtc_clk), .XTAL_STABLE_I(xtal_ok),
        .OSC_MODE_SELECT_O(mode), .GAIN_CONTROL_ENABLE_O(gain), .BIAS_DOUBLE_ENABLE_O(bias),
        .RTC_OSC_POWER_ENABLE_O(power), .SYS_CLOCK_SEL_RTC_O(sys_clk), .PIN_ROUTE_RTC_O(pin),
        .CAPTURE_EDGE_O(cap), .WAKE_REQ_O(wake), .IRQ_O(irq), .RESET_REQ_O(rstq));
    rtcoc_osc_model u_rtcoc_osc_model (.power_i(power), .mode_i(mode), .bias_i(bias), .hold_i(hold),
        .rtc_clk_o(rtc_clk), .xtal_stable_o(xtal_ok));

    task automatic complete_run;
        if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check($sformatf("reg %h", a), exp, rdata);
    endtask : rd_chk

    task automatic count_hi(input bit of_wake, input int cycles, output int n);
        n = 0;
        repeat (cycles) begin
            @(negedge clk);
            if ((of_wake ? wake : cap) === 1'b1) n++;
        end
    endtask : count_hi

    task automatic wait_wake;
        int n;
        n = 0;
        while (wake !== 1'b1) begin
            if (n == 900) begin
                bad_count++;
                complete_run();
            end
            @(negedge clk);
            n++;
        end
    endtask : wait_wake

    task automatic test_regs;
        for (int i = 0; i < 8; i++) begin
            wr_reg(4'h7, {i[2:0], 5'h00});
            @(negedge clk);
            check("osc outputs", {5'h00, i[2:0]}, {5'h00, gain, mode, bias});
            rd_chk(4'h7, {i[2:0], 5'h00});
        end
        for (int i = 0; i < 4; i++) begin
            wr_reg(4'hE, {6'h00, i[1:0]});
            @(negedge clk);
            check("route outputs", {6'h00, i[1:0]}, {6'h00, pin, sys_clk});
            rd_chk(4'hE, {6'h00, i[1:0]});
        end
        wr_reg(4'hF, 8'hFF);
        rd_chk(4'hF, 8'h03);
        wr_reg(4'h3, 8'hFF);
        rd_chk(4'h3, 8'h00);
        wr_reg(4'hF, 8'h00);
        wr_reg(4'hE, 8'h00);
    endtask : test_regs

    task automatic test_self_osc;
        int n;
        wr_reg(4'h7, 8'h20);
        wr_reg(4'h6, 8'h80);
        @(negedge clk);
        check("power output", 8'h01, {7'h00, power});
        rd_chk(4'h7, 8'h30);
        count_hi(1'b0, 2500, n);
        check("fast edges", 8'h01, {7'h00, (n >= 9 && n <= 11)});
        wr_reg(4'h7, 8'h00);
        count_hi(1'b0, 2500, n);
        check("slow edges", 8'h01, {7'h00, (n >= 4 && n <= 6)});
        wr_reg(4'h6, 8'h00);
    endtask : test_self_osc

    task automatic test_crystal;
        int n;
        wr_reg(4'h7, 8'h40);
        wr_reg(4'h7, 8'hC0);
        wr_reg(4'h7, 8'hE0);
        wr_reg(4'h6, 8'h80);
        rd_chk(4'h7, 8'hE0);
        n = 0;
        while (xtal_ok !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (n == 4000) begin
            bad_count++;
            complete_run();
        end
        repeat (4) @(negedge clk);
        rd_chk(4'h7, 8'hF0);
        wr_reg(4'h7, 8'hC0);
        rd_chk(4'h7, 8'hD0);
    endtask : test_crystal

    task automatic test_monitor;
        int n;
        wr_reg(4'hF, 8'h03);
        wr_reg(4'h6, 8'hC0);
        count_hi(1'b1, 1200, n);
        check("wake while running", 8'h00, n[7:0]);
        hold = 1'b1;
        wait_wake();
        check("irq and reset", 8'h03, {6'h00, irq, rstq});
        rd_chk(4'h6, 8'hE0);
        count_hi(1'b1, 700, n);
        check("one shot", 8'h00, n[7:0]);
        wr_reg(4'h6, 8'h80);
        rd_chk(4'h6, 8'h80);
        check("irq cleared", 8'h00, {7'h00, irq});
        wr_reg(4'hF, 8'h00);
        wr_reg(4'h6, 8'hC0);
        wait_wake();
        check("gated events", 8'h00, {6'h00, irq, rstq});
        wr_reg(4'h6, 8'h80);
        hold = 1'b0;
    endtask : test_monitor

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("reset outputs", 8'h00, {power, mode, gain, bias, sys_clk, pin, wake, irq});
        rd_chk(4'h6, 8'h00);
        rd_chk(4'h7, 8'h00);
        test_regs();
        test_self_osc();
        test_crystal();
        test_monitor();
        complete_run();
    end
endmodule : rtcoc_ctrl_bench

`default_nettype wire
